//--- design/pdm_port_drive_match.sv
// Function
// - one drive select bit per port 0-3
// - drive select bits reset to one
// - mask zero pin never causes mismatch
// - mask one pin compared to match bit
// - match bit zero compares against low
// - match bit one compares against high
// - mask bits reset to zero
// - match bits reset to one
`timescale 1ns/100ps
`default_nettype none

module pdm_port_drive_match
  import pdm_pkg::*;
#(
  parameter int unsigned PINS = 8
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire pdm_sfr_req_s               sfr_req,
  output logic [SFR_DW-1:0]               sfr_rdata,
  input  wire logic [PINS-1:0]            port0_pins,
  output logic [NUM_DRIVE_PORTS-1:0]      drive_select,
  output logic                            port_mismatch
);

  // ==========================================================================
  // pin synchroniser
  // pads are asynchronous: two flops before any use
  logic [PINS-1:0] pin_meta_q;
  logic [PINS-1:0] pin_sync_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= port0_pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ==========================================================================
  // registers
  logic [NUM_DRIVE_PORTS-1:0] drive_d, drive_q;
  logic [PINS-1:0]            match_d, match_q;
  logic [PINS-1:0]            mask_d, mask_q;
  logic [SFR_DW-1:0]          rdata_d, rdata_q;

  always_comb begin
    drive_d = drive_q;
    match_d = match_q;
    mask_d  = mask_q;
    rdata_d = rdata_q;
    if (sfr_req.wr) begin
      // reserved upper drive bits dropped on write
      case (sfr_req.addr)
        ADDR_PORT_DRIVE_STRENGTH: drive_d = sfr_req.wdata[NUM_DRIVE_PORTS-1:0];
        ADDR_PORT0_MATCH_VALUE:   match_d = sfr_req.wdata[PINS-1:0];
        ADDR_PORT0_COMPARE_MASK:  mask_d  = sfr_req.wdata[PINS-1:0];
        default: ;
      endcase
    end
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        // reserved upper bits read zero
        ADDR_PORT_DRIVE_STRENGTH: rdata_d = {{(SFR_DW-NUM_DRIVE_PORTS){1'b0}}, drive_q};
        ADDR_PORT0_MATCH_VALUE:   rdata_d = match_q;
        ADDR_PORT0_COMPARE_MASK:  rdata_d = mask_q;
        default:                  rdata_d = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drive_q <= DRIVE_SELECT_RESET;
      match_q <= MATCH_VALUE_RESET;
      mask_q  <= COMPARE_MASK_RESET;
      rdata_q <= READ_UNMAPPED;
    end else begin
      drive_q <= drive_d;
      match_q <= match_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // mismatch detector
  function automatic logic mismatch_f(input logic [PINS-1:0] pins,
                                      input logic [PINS-1:0] mat,
                                      input logic [PINS-1:0] msk);
    // per-pin xor against match level, gated by mask
    mismatch_f = |((pins ^ mat) & msk);
  endfunction : mismatch_f

  logic mism_d, mism_q;

  always_comb begin
    mism_d = mismatch_f(pin_sync_q, match_q, mask_q);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mism_q <= 1'b0;
    end else begin
      mism_q <= mism_d;
    end
  end

  assign sfr_rdata     = rdata_q;
  assign drive_select  = drive_q;
  assign port_mismatch = mism_q;

  // ==========================================================================
  // assertions: reset values
  drive_reset_val_a: assert property (@(posedge clk)
    sys_rst |=> drive_q == 4'hF)
    else $error("drive select not one after reset");

  mask_reset_val_a: assert property (@(posedge clk)
    sys_rst |=> mask_q == 8'h00)
    else $error("mask not zero after reset");

  match_reset_val_a: assert property (@(posedge clk)
    sys_rst |=> match_q == 8'hFF)
    else $error("match not ones after reset");

  event_reset_a: assert property (@(posedge clk)
    sys_rst |=> !port_mismatch)
    else $error("mismatch event during reset");

  // ==========================================================================
  // assertions: register access
  drive_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_req.wr && sfr_req.addr == ADDR_PORT_DRIVE_STRENGTH
    |=> drive_select == $past(sfr_req.wdata[3:0]))
    else $error("drive write lost");

  drive_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(sfr_req.wr && sfr_req.addr == ADDR_PORT_DRIVE_STRENGTH)
    |=> $stable(drive_select))
    else $error("drive select changed without write");

  mask_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_req.wr && sfr_req.addr == ADDR_PORT0_COMPARE_MASK
    |=> mask_q == $past(sfr_req.wdata))
    else $error("mask write lost");

  mask_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(sfr_req.wr && sfr_req.addr == ADDR_PORT0_COMPARE_MASK)
    |=> $stable(mask_q))
    else $error("mask changed without write");

  match_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_req.wr && sfr_req.addr == ADDR_PORT0_MATCH_VALUE
    |=> match_q == $past(sfr_req.wdata))
    else $error("match write lost");

  match_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(sfr_req.wr && sfr_req.addr == ADDR_PORT0_MATCH_VALUE)
    |=> $stable(match_q))
    else $error("match changed without write");

  drive_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_req.rd && sfr_req.addr == ADDR_PORT_DRIVE_STRENGTH
    |=> sfr_rdata == {4'h0, $past(drive_select)})
    else $error("drive select read wrong");

  mask_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_req.rd && sfr_req.addr == ADDR_PORT0_COMPARE_MASK
    |=> sfr_rdata == $past(mask_q))
    else $error("mask read wrong");

  match_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    sfr_req.rd && sfr_req.addr == ADDR_PORT0_MATCH_VALUE
    |=> sfr_rdata == $past(match_q))
    else $error("match read wrong");

  // ==========================================================================
  // assertions: mismatch detector
  pin_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(sys_rst, 2) |-> pin_sync_q == $past(port0_pins, 2))
    else $error("pin synchroniser delay wrong");

  masked_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    mask_q == 8'h00 && $past(mask_q) == 8'h00 |=> !port_mismatch)
    else $error("mismatch with all pins masked");

  mismatch_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    |(mask_q & match_q & ~pin_sync_q) |=> port_mismatch)
    else $error("low pin vs high match missed");

  mismatch_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    |(mask_q & ~match_q & pin_sync_q) |=> port_mismatch)
    else $error("high pin vs low match missed");

  all_match_a: assert property (@(posedge clk) disable iff (sys_rst)
    ((pin_sync_q ^ match_q) & mask_q) == 8'h00 |=> !port_mismatch)
    else $error("mismatch while all compared pins match");

  mismatch_exact_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> port_mismatch == $past(|((pin_sync_q ^ match_q) & mask_q)))
    else $error("mismatch output wrong");

  pin_path_a: assert property (@(posedge clk) disable iff (sys_rst)
    mask_q == 8'h01 && match_q == 8'hFF && $stable(mask_q) && $stable(match_q)
    ##0 !pin_sync_q[0] |=> port_mismatch)
    else $error("pin 0 low not flagged");

  // cover points
  mismatch_seen_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(port_mismatch));
  mismatch_gone_c: cover property (@(posedge clk) disable iff (sys_rst) $fell(port_mismatch));
  low_drive_c:     cover property (@(posedge clk) disable iff (sys_rst) drive_select == 4'h0);
  single_pin_c:    cover property (@(posedge clk) disable iff (sys_rst)
    mask_q == 8'h01 && !pin_sync_q[0] ##1 port_mismatch);
  masked_diff_c:   cover property (@(posedge clk) disable iff (sys_rst)
    ((pin_sync_q ^ match_q) & ~mask_q) != 8'h00 ##1 !port_mismatch);

endmodule : pdm_port_drive_match

`default_nettype wire

//--- shared/pdm_pkg.sv
// ==========================================================================
// port drive and match detect constants
package pdm_pkg;
  localparam int unsigned SFR_AW = 8;
  localparam int unsigned SFR_DW = 8;

  // ==========================================================================
  // register addresses
  localparam logic [7:0] ADDR_PORT_DRIVE_STRENGTH  = 8'hF6;
  localparam logic [7:0] ADDR_PORT0_MATCH_VALUE    = 8'hFD;
  localparam logic [7:0] ADDR_PORT0_COMPARE_MASK   = 8'hFE;

  // ==========================================================================
  // field layout and reset values
  localparam int unsigned NUM_DRIVE_PORTS          = 4;
  localparam logic [3:0] DRIVE_SELECT_RESET        = 4'hF;
  localparam logic [7:0] MATCH_VALUE_RESET         = 8'hFF;
  localparam logic [7:0] COMPARE_MASK_RESET        = 8'h00;
  localparam logic [7:0] READ_UNMAPPED             = 8'h00;

  // ==========================================================================
  // special-function-register access
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [SFR_AW-1:0] addr;
    logic [SFR_DW-1:0] wdata;
  } pdm_sfr_req_s;
endpackage : pdm_pkg

//--- verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pdm_pkg::*;
  logic                      clk;
  logic                      sys_rst;
  pdm_sfr_req_s              req;
  logic [SFR_DW-1:0]         rdata;
  logic [7:0]                pins, m, k, d;
  logic [NUM_DRIVE_PORTS-1:0] drv;
  logic                      mis;
  int                        err_total, checks_done, seed, i;

  pdm_port_drive_match dut (.clk(clk), .sys_rst(sys_rst), .sfr_req(req), .sfr_rdata(rdata),
    .port0_pins(pins), .drive_select(drv), .port_mismatch(mis));

  // ==========================================================================
  // helpers
  function automatic logic exp_mis(input logic [7:0] p, mt, mk);
    logic hit;
    hit = 1'b0;
    for (int b = 0; b < 8; b++) begin
      if (mk[b] && (p[b] != mt[b])) hit = 1'b1;
    end
    return hit;
  endfunction : exp_mis
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dt};
    @(posedge clk) req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk) req <= '0;
    @(posedge clk) #1;
    chk(rdata === e, "read data");
  endtask : rd
  task automatic mchk(input logic [7:0] p);
    @(posedge clk) pins <= p;
    repeat (5) @(posedge clk);
    #1 chk(mis === exp_mis(p, m, k), "mismatch level");
  endtask : mchk
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // ==========================================================================
  // clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 4000);
    err_total++;
    finish_test();
  end
  initial begin
    seed = 32'h6C05802B; req = '0; pins = 8'hFF; sys_rst = 1'b1; m = 8'hFF; k = 8'h00;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_PORT_DRIVE_STRENGTH, 8'h0F);
    chk(drv === 4'hF, "drive reset");
    rd(ADDR_PORT0_MATCH_VALUE, 8'hFF);
    rd(ADDR_PORT0_COMPARE_MASK, 8'h00);
    rd(8'h10, 8'h00);
    mchk(8'h00);
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hF0 : 8'($random(seed));
      wr(ADDR_PORT_DRIVE_STRENGTH, d);
      rd(ADDR_PORT_DRIVE_STRENGTH, {4'h0, d[3:0]});
      chk(drv === d[3:0], "drive select");
    end
    $display("drive test done");
    k = 8'hFF; m = 8'h00;
    wr(ADDR_PORT0_COMPARE_MASK, k);
    wr(ADDR_PORT0_MATCH_VALUE, m);
    mchk(8'h00);
    m = 8'hFF;
    wr(ADDR_PORT0_MATCH_VALUE, m);
    mchk(8'h00);
    k = 8'h01;
    wr(ADDR_PORT0_COMPARE_MASK, k);
    mchk(8'hFE);
    mchk(8'h01);
    for (i = 0; i < 40; i++) begin
      m = 8'($random(seed));
      k = 8'($random(seed));
      wr(ADDR_PORT0_MATCH_VALUE, m);
      wr(ADDR_PORT0_COMPARE_MASK, k);
      mchk((i % 2 == 0) ? (m ^ ~k) : 8'($random(seed)));
      rd(ADDR_PORT0_COMPARE_MASK, k);
    end
    $display("match test done");
    @(posedge clk) sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_PORT_DRIVE_STRENGTH, 8'h0F);
    rd(ADDR_PORT0_MATCH_VALUE, 8'hFF);
    rd(ADDR_PORT0_COMPARE_MASK, 8'h00);
    chk(drv === 4'hF && mis === 1'b0, "state after second reset");
    $display("second reset test done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
